/* File: scmc_command_mode.sv */
// Escape detection, command-mode configuration store and APB register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module scmc_command_mode #(
   parameter int TICK_CYCLES = scmc_pkg::GUARD_UNIT_CYCLES,
   parameter int BREAK_CYCLES = scmc_pkg::BREAK_MIN_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic serial_data_in,
   input wire logic [31:0] serial_number,
   output logic command_mode,
   output logic data_valid,
   output logic [7:0] data_char,
   output logic [19:0] active_rate,
   output logic remote_break,
   output scmc_pkg::scmc_cfg_t cfg
);
   scmc_pkg::scmc_state_t state; // Escape detector state
   logic [1:0] seq_seen; // Sequence characters seen so far
   logic [15:0] silent_units; // Silence since last character
   logic [15:0] before_eff; // Guard before in force
   logic [15:0] after_eff; // Guard after in force
   logic din_meta; // First synchroniser stage
   logic din_sync; // Second synchroniser stage
   logic [$clog2(BREAK_CYCLES+1)-1:0] low_count; // Low time of the input line
   logic [31:0] param; // Parameter register
   logic [31:0] result; // Result of last command
   logic cmd_err; // Last command refused
   logic apb_write; // Write taken this cycle
   logic cmd_go; // Command register written
   logic [7:0] cmd_code; // Code being executed
   logic cmd_query; // Query without argument
   logic [19:0] rate_arg; // Rate argument, clipped
   logic [19:0] rate_store; // Rate after rounding
   logic [15:0] auto_addr; // Address built from serial number

   // Silence measurement on received characters
   scmc_silence_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_silence (
      .pclk(pclk),
      .presetn(presetn),
      .char_seen(rx_valid),
      .silent_units(silent_units)
   );

   // Both guards zero selects the fast 0.6 s guards
   always_comb begin
      if (cfg.guard_before == '0 && cfg.guard_after == '0) begin
         before_eff = scmc_pkg::FAST_GUARD_UNITS;
         after_eff = scmc_pkg::FAST_GUARD_UNITS;
      end else begin
         before_eff = cfg.guard_before;
         after_eff = cfg.guard_after;
      end
   end

   // Rate the divider can make: divisor rounded up, rate recomputed, so the
   // stored rate never exceeds the request and the host is never overrun
   function automatic logic [19:0] round_rate(input logic [19:0] r);
      int d;
      d = (scmc_pkg::RATE_REF + int'(r) - 1) / int'(r);
      if (d < 1) begin
         d = 1;
      end
      return 20'(scmc_pkg::RATE_REF / d);
   endfunction

   // Command decode helpers
   always_comb begin
      cmd_code = pwdata[7:0];
      cmd_query = pwdata[scmc_pkg::CMD_QUERY_BIT];
      rate_arg = (param[31:20] != '0) ? 20'hfffff : param[19:0];
      // Codes 0..7 select standard rates and are kept as written
      if (rate_arg <= scmc_pkg::RATE_STD_MAX) begin
         rate_store = rate_arg;
      end else begin
         rate_store = round_rate(rate_arg);
      end
      auto_addr = {serial_number[scmc_pkg::SN_HI_BIT], serial_number[scmc_pkg::SN_MID_BIT],
                   serial_number[scmc_pkg::SN_LOW_TOP:0]};
   end

   // APB: one wait cycle, so every access completes on its second access edge
   assign apb_write = psel && penable && pready && pwrite;
   assign cmd_go = apb_write && paddr == scmc_pkg::ADDR_CMD;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // Read data and error are captured with pready so they stand with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pslverr <= 1'b0;
         prdata <= '0;
         case (paddr)
            scmc_pkg::ADDR_CMD: begin
               prdata <= '0; // Write-only, reads zero
            end
            scmc_pkg::ADDR_PARAM: begin
               prdata <= param;
            end
            scmc_pkg::ADDR_RESULT: begin
               prdata <= result;
            end
            scmc_pkg::ADDR_STATUS: begin
               prdata[scmc_pkg::ST_MODE_BIT] <= command_mode;
               prdata[scmc_pkg::ST_BREAK_BIT] <= remote_break;
               prdata[scmc_pkg::ST_ERR_BIT] <= cmd_err;
            end
            default: begin
               pslverr <= 1'b1; // Unmapped address
            end
         endcase
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Parameter register for the next command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         param <= '0;
      end else if (apb_write && paddr == scmc_pkg::ADDR_PARAM) begin
         param <= pwdata;
      end
   end

   // Escape detector: guard silence, three sequence chars, guard silence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= scmc_pkg::ST_IDLE;
         seq_seen <= '0;
      end else begin
         case (state)
            scmc_pkg::ST_IDLE: begin
               // Silence is measured before the timer clears on this char
               if (rx_valid && rx_char == cfg.sequence_char &&
                   silent_units >= before_eff) begin
                  state <= scmc_pkg::ST_SEQ;
                  seq_seen <= 2'h1;
               end
            end
            scmc_pkg::ST_SEQ: begin
               if (rx_valid && rx_char == cfg.sequence_char) begin
                  seq_seen <= seq_seen + 2'h1;
                  if (seq_seen + 2'h1 == scmc_pkg::SEQ_COUNT) begin
                     state <= scmc_pkg::ST_AFTER;
                  end
               end else if (rx_valid) begin
                  state <= scmc_pkg::ST_IDLE;
               end
            end
            scmc_pkg::ST_AFTER: begin
               if (rx_valid) begin
                  state <= scmc_pkg::ST_IDLE;
               end else if (silent_units >= after_eff) begin
                  state <= scmc_pkg::ST_CMD;
               end
            end
            scmc_pkg::ST_CMD: begin
               if (cmd_go && !cmd_query && cmd_code == scmc_pkg::CODE_EXIT) begin
                  state <= scmc_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= scmc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Mode flag follows the state one cycle later, from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         command_mode <= 1'b0;
      end else begin
         command_mode <= (state == scmc_pkg::ST_CMD);
      end
   end

   // Characters outside command mode pass on as data, sequence chars too;
   // downstream cannot tell an aborted escape from payload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_valid <= 1'b0;
         data_char <= '0;
      end else begin
         data_valid <= rx_valid && state != scmc_pkg::ST_CMD;
         data_char <= rx_char;
      end
   end

   // Configuration store; commands only act in command mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg.source_address <= '0;
         cfg.guard_before <= scmc_pkg::GUARD_DEFAULT;
         cfg.guard_after <= scmc_pkg::GUARD_DEFAULT;
         cfg.sequence_char <= scmc_pkg::SEQ_CHAR_DEFAULT;
         cfg.interface_rate_select <= scmc_pkg::RADIO_RATE_CODE;
         cfg.break_pass_enable <= 1'b0;
         result <= '0;
         cmd_err <= 1'b0;
      end else if (cmd_go) begin
         cmd_err <= 1'b0;
         if (state != scmc_pkg::ST_CMD) begin
            cmd_err <= 1'b1;
         end else begin
            case (cmd_code)
               scmc_pkg::CODE_AUTO_ADDR: begin
                  cfg.source_address <= auto_addr;
                  result <= {16'h0000, auto_addr};
               end
               scmc_pkg::CODE_GUARD_AFTER: begin
                  if (!cmd_query) begin
                     cfg.guard_after <= param[15:0];
                  end
                  result <= {16'h0000, cmd_query ? cfg.guard_after : param[15:0]};
               end
               scmc_pkg::CODE_GUARD_BEFORE: begin
                  // Zero is let through so fast entry can be chosen
                  if (!cmd_query && param[15:0] != '0 &&
                      param[15:0] < scmc_pkg::GUARD_BEFORE_MIN) begin
                     cmd_err <= 1'b1;
                  end else if (!cmd_query) begin
                     cfg.guard_before <= param[15:0];
                  end
                  result <= {16'h0000, cfg.guard_before};
               end
               scmc_pkg::CODE_SEQ_CHAR: begin
                  if (!cmd_query && (param[7:0] < scmc_pkg::SEQ_CHAR_MIN ||
                      param[7:0] > scmc_pkg::SEQ_CHAR_MAX || param[31:8] != '0)) begin
                     cmd_err <= 1'b1;
                  end else if (!cmd_query) begin
                     cfg.sequence_char <= param[7:0];
                  end
                  result <= {24'h000000, cfg.sequence_char};
               end
               scmc_pkg::CODE_RATE: begin
                  if (cmd_query) begin
                     result <= {12'h000, cfg.interface_rate_select};
                  end else begin
                     cfg.interface_rate_select <= rate_store;
                     result <= {12'h000, rate_store};
                  end
               end
               scmc_pkg::CODE_BREAK: begin
                  if (!cmd_query && param[31:1] != '0) begin
                     cmd_err <= 1'b1;
                  end else if (!cmd_query) begin
                     cfg.break_pass_enable <= param[0];
                  end
                  result <= {31'h00000000, cfg.break_pass_enable};
               end
               scmc_pkg::CODE_EXIT: begin
                  result <= '0;
               end
               default: begin
                  cmd_err <= 1'b1; // Unknown code
               end
            endcase
         end
      end
   end

   // The UART rate changes only when command mode is left
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_rate <= scmc_pkg::RADIO_RATE_CODE;
      end else if (cmd_go && !cmd_query && cmd_code == scmc_pkg::CODE_EXIT &&
                   state == scmc_pkg::ST_CMD) begin
         active_rate <= cfg.interface_rate_select;
      end
   end

   // Two-stage synchroniser on the serial input pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_meta <= 1'b1;
         din_sync <= 1'b1;
      end else begin
         din_meta <= serial_data_in;
         din_sync <= din_meta;
      end
   end

   // Break is a low line held past the minimum time; passed only if enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_count <= '0;
         remote_break <= 1'b0;
      end else begin
         if (din_sync) begin
            low_count <= '0;
         end else if (low_count != $bits(low_count)'(BREAK_CYCLES)) begin
            low_count <= low_count + 1'b1;
         end
         remote_break <= cfg.break_pass_enable && !din_sync &&
                         low_count == $bits(low_count)'(BREAK_CYCLES);
      end
   end
endmodule // scmc_command_mode

/* File: scmc_silence_timer.sv */
// Constants package and the serial silence timer used by the escape detector
package scmc_pkg;
   // Clock and time base
   localparam int CLK_HZ = 20_000_000;
   localparam int GUARD_UNIT_MS = 100;
   localparam int GUARD_UNIT_CYCLES = CLK_HZ / 1000 * GUARD_UNIT_MS;
   localparam int BREAK_MIN_US = 1000;
   localparam int BREAK_MIN_CYCLES = CLK_HZ / 1_000_000 * BREAK_MIN_US;
   localparam int FAST_GUARD_MS = 600;
   localparam logic [15:0] FAST_GUARD_UNITS = 16'(FAST_GUARD_MS / GUARD_UNIT_MS);
   // Reset values, limits and other fixed constants
   localparam logic [15:0] GUARD_DEFAULT = 16'h000a;
   localparam logic [15:0] GUARD_BEFORE_MIN = 16'h0002;
   localparam logic [7:0] SEQ_CHAR_DEFAULT = 8'h2d;
   localparam logic [7:0] SEQ_CHAR_MIN = 8'h20;
   localparam logic [7:0] SEQ_CHAR_MAX = 8'h7f;
   localparam logic [19:0] RADIO_RATE_CODE = 20'h00003;
   localparam logic [19:0] RATE_STD_MAX = 20'h00007;
   localparam int RATE_REF = 1_000_000;
   localparam logic [1:0] SEQ_COUNT = 2'h3;
   // Command codes
   localparam logic [7:0] CODE_AUTO_ADDR = 8'h3a;
   localparam logic [7:0] CODE_GUARD_AFTER = 8'h05;
   localparam logic [7:0] CODE_GUARD_BEFORE = 8'h04;
   localparam logic [7:0] CODE_SEQ_CHAR = 8'h13;
   localparam logic [7:0] CODE_RATE = 8'h15;
   localparam logic [7:0] CODE_BREAK = 8'h2d;
   localparam logic [7:0] CODE_EXIT = 8'h09;
   // Serial number fields
   localparam int SN_HI_BIT = 29;
   localparam int SN_MID_BIT = 28;
   localparam int SN_LOW_TOP = 13;
   // APB map
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_PARAM = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam int CMD_QUERY_BIT = 8;
   localparam int ST_MODE_BIT = 0;
   localparam int ST_BREAK_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   // Escape detector states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEQ = 4'b0010,
      ST_AFTER = 4'b0100,
      ST_CMD = 4'b1000
   } scmc_state_t;
   // Stored configuration
   typedef struct packed {
      logic [15:0] source_address;
      logic [15:0] guard_before;
      logic [15:0] guard_after;
      logic [7:0] sequence_char;
      logic [19:0] interface_rate_select;
      logic break_pass_enable;
   } scmc_cfg_t;
endpackage

`timescale 1ns/1ns
// Counts whole guard units of silence since the last received character
module scmc_silence_timer #(
   parameter int TICK_CYCLES = scmc_pkg::GUARD_UNIT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic char_seen,
   output logic [15:0] silent_units
);
   localparam int DW = $clog2(TICK_CYCLES + 1);
   logic [DW-1:0] div; // Cycle count within one unit

   // Divider restarts with each character so units are measured from it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= '0;
      end else if (char_seen || div == DW'(TICK_CYCLES - 1)) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end

   // Saturating unit count; a long silence must not wrap to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         silent_units <= '0;
      end else if (char_seen) begin
         silent_units <= '0;
      end else if (div == DW'(TICK_CYCLES - 1) && silent_units != 16'hffff) begin
         silent_units <= silent_units + 16'h0001;
      end
   end
endmodule // scmc_silence_timer

/* File: scmc_checker_monitor.sv */
// Port-level checker for the command-mode block, bound to its top module
`timescale 1ns/1ns
module scmc_checker_monitor #(
   parameter int TICK_CYCLES = 10,
   parameter int BREAK_CYCLES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic serial_data_in,
   input wire logic [31:0] serial_number,
   input wire logic command_mode,
   input wire logic data_valid,
   input wire logic [7:0] data_char,
   input wire logic [19:0] active_rate,
   input wire logic remote_break,
   input wire scmc_pkg::scmc_cfg_t cfg
);
   // One clock domain, so one clocking and one disable
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_slverr_map: assert property (pready && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   a_data_echo: assert property (data_valid |-> $past(rx_valid) && data_char == $past(rx_char))
      else $error("forwarded data does not match input");
   a_entry_quiet: assert property ($rose(command_mode) |-> !$past(rx_valid) && !$past(rx_valid, 2))
      else $error("entry without trailing silence");
   a_exit_cause: assert property ($fell(command_mode) |-> $past(psel && penable && pready && pwrite
      && paddr == scmc_pkg::ADDR_CMD && pwdata[7:0] == scmc_pkg::CODE_EXIT, 2))
      else $error("left command mode without exit");
   a_rate_apply: assert property ($changed(active_rate) |=> $fell(command_mode))
      else $error("rate changed outside exit");
   a_rate_take: assert property ($fell(command_mode) |-> active_rate == cfg.interface_rate_select)
      else $error("exit did not apply stored rate");
   a_cfg_range: assert property (cfg.guard_before != 16'h0001
      && cfg.sequence_char inside {[8'h20:8'h7f]})
      else $error("configuration out of range");
   a_break_src: assert property ($rose(remote_break)
      |-> cfg.break_pass_enable && !$past(serial_data_in, 3))
      else $error("break passed without cause");
   a_break_end: assert property (serial_data_in [*5] |-> !remote_break)
      else $error("break held after line idle");
   // Main scenarios
   c_entry: cover property ($rose(command_mode));
   c_break: cover property ($rose(remote_break));
   c_refused: cover property (pready && pslverr);
endmodule // scmc_checker_monitor

bind scmc_command_mode scmc_checker_monitor #(.TICK_CYCLES(TICK_CYCLES),
   .BREAK_CYCLES(BREAK_CYCLES)) i_scmc_checker_monitor (.*);

/* File: scmc_host_term.sv */
// Host terminal model: paced characters, escape sequences and line breaks
`timescale 1ns/1ns
module scmc_host_term (
   input wire logic pclk,
   output logic rx_valid,
   output logic [7:0] rx_char,
   output logic serial_data_in
);
   // Line idles high; no character offered at start
   initial begin
      rx_valid = 1'b0;
      rx_char = 8'h00;
      serial_data_in = 1'b1;
   end
   // Gap after each char keeps the host well below the block's pace
   task automatic send_char(input logic [7:0] c);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_char <= c;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_char <= ~c; // Stale char never shown outside the strobe
      repeat (3) @(posedge pclk);
   endtask
   // Silence, then three chars; a foreign middle char makes an abort
   task automatic escape(input int quiet, input logic [7:0] c, input logic [7:0] mid);
      repeat (quiet) @(posedge pclk);
      send_char(c);
      send_char(mid);
      send_char(c);
   endtask
   // Hold the raw line at a level for some cycles
   task automatic set_line(input logic v, input int n);
      serial_data_in <= v;
      repeat (n) @(posedge pclk);
   endtask
endmodule // scmc_host_term

/* File: test_serial_command_mode_config.sv */
// Self-checking bench for the command-mode block
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR at %0t: got %h expected %h", $time, g, e); end end
module test_serial_command_mode_config;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic rx_valid, serial_data_in, command_mode, data_valid, remote_break;
   logic [7:0] paddr, rx_char, data_char;
   logic [7:0] exp_c; // Next character expected on the data output
   logic [7:0] sent_q[$]; // Characters offered by the host, in order
   logic [31:0] pwdata, prdata, serial_number, rd;
   logic [19:0] active_rate;
   scmc_pkg::scmc_cfg_t cfg;
   int err_total = 0, tests_run = 0, cyc = 0, data_cnt = 0, n;
   int vals[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 'h12c, 'h1c200}; // Rate values to set
   // Short guard unit and break time keep the run small
   scmc_command_mode #(.TICK_CYCLES(10), .BREAK_CYCLES(8)) i_scmc_command_mode (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_char(rx_char), .serial_data_in(serial_data_in),
      .serial_number(serial_number), .command_mode(command_mode), .data_valid(data_valid),
      .data_char(data_char), .active_rate(active_rate), .remote_break(remote_break), .cfg(cfg));
   scmc_host_term i_scmc_host_term (.pclk(pclk), .rx_valid(rx_valid), .rx_char(rx_char),
      .serial_data_in(serial_data_in));
   // 50 ns clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction
   // Reference rounding: largest divisor rate not above the request
   function automatic int exp_rate(input int v);
      int d;
      if (v <= 7) return v;
      d = (1000000 + v - 1) / v;
      return 1000000 / d;
   endfunction
   // One APB transfer; answer taken at the edge that sees pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Parameter, command, then result read back into rd
   task automatic cmd(input logic [8:0] code, input logic [31:0] p);
      apb(1'b1, scmc_pkg::ADDR_PARAM, p);
      apb(1'b1, scmc_pkg::ADDR_CMD, {23'h0, code});
      apb(1'b0, scmc_pkg::ADDR_RESULT, 32'h0);
   endtask
   // Cycles from the last escape char until command mode shows
   task automatic wait_mode(input int lo, input int hi);
      n = 0;
      while (command_mode !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1)
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Forwarded data count and hang guard
   always @(posedge pclk) begin
      // Every host character outside command mode comes out in order
      if (data_valid === 1'b1) begin
         data_cnt++;
         exp_c = sent_q.pop_front();
         `CHK(data_char, exp_c)
      end
      if (rx_valid === 1'b1) sent_q.push_back(rx_char);
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      serial_number = 32'h32;
      repeat (6) serial_number = lfsr(serial_number);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(cfg.guard_after, 16'h000a)
      `CHK(cfg.guard_before, 16'h000a)
      `CHK(cfg.sequence_char, 8'h2d)
      `CHK(cfg.break_pass_enable, 1'b0)
      `CHK(active_rate, scmc_pkg::RADIO_RATE_CODE)
      // Rate command outside command mode is refused
      cmd(9'h015, 32'h4);
      apb(1'b0, scmc_pkg::ADDR_STATUS, 32'h0);
      `CHK({rd[2], cfg.interface_rate_select}, {1'b1, 20'h00003})
      apb(1'b0, 8'h10, 32'h0);
      `CHK({se, rd}, {1'b1, 32'h0})
      // No leading silence: chars are only data
      i_scmc_host_term.escape(0, 8'h2d, 8'h2d);
      repeat (150) @(posedge pclk);
      `CHK({command_mode, data_cnt}, {1'b0, 32'd3})
      // Foreign middle char, then a late char in the after-guard
      i_scmc_host_term.escape(110, 8'h2d, 8'h41);
      repeat (150) @(posedge pclk);
      `CHK(command_mode, 1'b0)
      i_scmc_host_term.escape(110, 8'h2d, 8'h2d);
      repeat (40) @(posedge pclk);
      i_scmc_host_term.send_char(8'h2d);
      repeat (150) @(posedge pclk);
      `CHK(command_mode, 1'b0)
      i_scmc_host_term.escape(110, 8'h2d, 8'h2d);
      wait_mode(88, 110);
      cmd(9'h03a, 32'h0);
      `CHK({rd[15:0], cfg.source_address}, {2{serial_number[29:28], serial_number[13:0]}})
      // Every rate code and the rounded values, stored then queried
      foreach (vals[i]) begin
         cmd(9'h015, vals[i]);
         `CHK(rd[19:0], 20'(exp_rate(vals[i])))
         cmd(9'h115, 32'h0);
         `CHK({rd[19:0], active_rate}, {20'(exp_rate(vals[i])), 20'h00003})
      end
      cmd(9'h004, 32'h1);
      apb(1'b0, scmc_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[2], 1'b1)
      cmd(9'h013, 32'h1f);
      apb(1'b0, scmc_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[2], 1'b1)
      cmd(9'h013, 32'h2b);
      cmd(9'h005, 32'h0);
      cmd(9'h004, 32'h0);
      cmd(9'h02d, 32'h1);
      `CHK({cfg.sequence_char, cfg.guard_after, cfg.break_pass_enable}, {8'h2b, 16'h0000, 1'b1})
      cmd(9'h009, 32'h0);
      repeat (3) @(posedge pclk);
      `CHK({command_mode, active_rate}, {1'b0, 20'h1b207})
      // Zero guards give the short fixed guard
      i_scmc_host_term.escape(70, 8'h2b, 8'h2b);
      wait_mode(48, 70);
      cmd(9'h009, 32'h0);
      // Break held low is passed on, released line ends it
      i_scmc_host_term.set_line(1'b0, 20);
      `CHK(remote_break, 1'b1)
      i_scmc_host_term.set_line(1'b1, 6);
      `CHK(remote_break, 1'b0)
      end_of_test();
   end
endmodule // test_serial_command_mode_config
